// [src/acc_top.v]
// Function
// [RULE_01] Two independent comparators, output or interrupt
// [RULE_02] Three reference choices per comparator
// [RULE_03] Output 1 when negative below positive
// [RULE_04] Negative from pin, positive selectable
// [RULE_05] Cmp0 codes 00/01 use own pin
// [RULE_06] Cmp0 10 internal reference, 11 reserved
// [RULE_07] Cmp1 code 01 uses cmp0 positive pin
// [RULE_08] Cmp1 code 10 internal reference, interrupt
// [RULE_09] Only cmp0 drives shared output pin
// [RULE_10] Result raises interrupts, optional pin
// [RULE_11] Control, status, reference and interrupt registers
// [RULE_12] Software disables pad digital input buffers
// [RULE_13] Shared pin: cmp0 output or cmp1 input
// [RULE_14] Status register shows current result
// [RULE_15] Results synchronised to system clock
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`include "acc_consts.vh"
module acc_top (
  clk,                   // System clock 40 MHz
  rst_n,                 // Synchronous reset, active low
  haddr,                 // AHB address
  htrans,                // AHB transfer type
  hwrite,                // AHB write
  hsize,                 // AHB size
  hwdata,                // AHB write data
  hsel,                  // AHB slave select
  hready,                // AHB ready in
  hrdata,                // AHB read data
  hreadyout,             // AHB ready out
  hresp,                 // AHB response
  cmp0_result_raw,       // Analog result of comparator 0
  cmp1_result_raw,       // Analog result of comparator 1
  cmp0_pos_sel,          // Analog mux select, comparator 0 positive
  cmp1_pos_sel,          // Analog mux select, comparator 1 positive
  ref_enable,            // Reference ladder enable
  ref_range,             // Reference ladder range
  ref_tap,               // Reference ladder tap
  shared_pin_out,        // Shared pin output value
  shared_pin_oe,         // Shared pin output enable
  irq                    // Level interrupt
);
  input  wire        clk;             // Clock
  input  wire        rst_n;           // Reset, active low
  input  wire [31:0] haddr;           // Address
  input  wire [1:0]  htrans;          // Transfer type
  input  wire        hwrite;          // Write
  input  wire [2:0]  hsize;           // Size
  input  wire [31:0] hwdata;          // Write data
  input  wire        hsel;            // Select
  input  wire        hready;          // Ready in
  output reg  [31:0] hrdata;          // Read data
  output wire        hreadyout;       // Ready out
  output wire        hresp;           // Response
  input  wire        cmp0_result_raw; // Comparator 0 result
  input  wire        cmp1_result_raw; // Comparator 1 result
  output wire [1:0]  cmp0_pos_sel;    // Cmp0 positive mux
  output wire [1:0]  cmp1_pos_sel;    // Cmp1 positive mux
  output wire        ref_enable;      // Ladder enable
  output wire        ref_range;       // Ladder range
  output wire [3:0]  ref_tap;         // Ladder tap
  output reg         shared_pin_out;  // Shared pin value
  output reg         shared_pin_oe;   // Shared pin enable
  output reg         irq;             // Interrupt

  localparam NUM_CMP = 2; // Comparator count

  reg  [31:0] ctl_reg [0:NUM_CMP-1]; // Per-comparator control
  reg  [31:0] refctl_reg;            // Reference control
  reg  [1:0]  ris_reg;               // Raw interrupt status
  reg  [1:0]  inten_reg;             // Interrupt enable
  reg  [1:0]  ris_next;              // Next raw status
  reg         wr_pend_reg;           // Write data phase pending
  reg  [7:0]  wr_addr_reg;           // Latched write offset
  wire [NUM_CMP-1:0] raw_in;         // Raw comparator inputs
  wire [NUM_CMP-1:0] result;         // Synchronised results
  wire [NUM_CMP-1:0] evt;            // Event pulses
  wire        addr_phase;            // Valid address phase
  wire        rd_now;                // Read address phase
  wire [7:0]  off;                   // Byte offset
  wire [1:0]  mis;                   // Masked status

  assign raw_in = {cmp1_result_raw, cmp0_result_raw};

  // Decode offset into register identity
  function [3:0] reg_sel;
    input [7:0] o;
    begin
      case (o)
        `ACC_OFF_MIS:    reg_sel = 4'h1;
        `ACC_OFF_RIS:    reg_sel = 4'h2;
        `ACC_OFF_INTEN:  reg_sel = 4'h3;
        `ACC_OFF_REFCTL: reg_sel = 4'h4;
        `ACC_OFF_STAT0:  reg_sel = 4'h5;
        `ACC_OFF_CTL0:   reg_sel = 4'h6;
        `ACC_OFF_STAT1:  reg_sel = 4'h7;
        `ACC_OFF_CTL1:   reg_sel = 4'h8;
        default:         reg_sel = 4'h0;
      endcase
    end
  endfunction

  // Independent comparator units
  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g = g + 1)
    begin : g_unit
      acc_unit u_unit (
        .clk       (clk),
        .rst_n     (rst_n),
        .raw_cmp   (raw_in[g]),
        .invert    (ctl_reg[g][`ACC_CTL_INV_BIT]),
        .sense     (ctl_reg[g][`ACC_CTL_ISEN_HI:`ACC_CTL_ISEN_LO]),
        .result    (result[g]),
        .event_hit (evt[g])
      ); // [RULE_01] [RULE_10]
    end
  endgenerate

  // Positive source selection; negatives are always pins
  assign cmp0_pos_sel = ctl_reg[0][`ACC_CTL_SRC_HI:`ACC_CTL_SRC_LO]; // [RULE_02] [RULE_04]
  assign cmp1_pos_sel = ctl_reg[1][`ACC_CTL_SRC_HI:`ACC_CTL_SRC_LO]; // [RULE_07] [RULE_08]
  assign ref_enable   = refctl_reg[`ACC_REF_EN_BIT];
  assign ref_range    = refctl_reg[`ACC_REF_RNG_BIT];
  assign ref_tap      = refctl_reg[`ACC_REF_TAP_HI:`ACC_REF_TAP_LO];

  // Bus handshake: zero wait states, always OKAY
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign addr_phase = hsel & hready & htrans[1];
  assign rd_now     = addr_phase & ~hwrite;
  assign off        = haddr[7:0];
  assign mis        = ris_reg & inten_reg;

  // Raw status: events set, read of status clears, set wins
  always @*
  begin
    ris_next = ris_reg;
    if (rd_now && (reg_sel(off) == 4'h1 || reg_sel(off) == 4'h2))
      ris_next = 2'b00;
    if (wr_pend_reg && reg_sel(wr_addr_reg) == 4'h1)
      ris_next = ris_next & ~hwdata[1:0];
    ris_next = ris_next | evt; // [RULE_10]
  end

  // Register writes and status update
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctl_reg[0]  <= `ACC_RST_ZERO;
      ctl_reg[1]  <= `ACC_RST_ZERO;
      refctl_reg  <= `ACC_RST_ZERO;
      inten_reg   <= 2'b00;
      ris_reg     <= 2'b00;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else
    begin
      ris_reg     <= ris_next;
      wr_pend_reg <= addr_phase & hwrite;
      wr_addr_reg <= off;
      if (wr_pend_reg)
      begin
        case (reg_sel(wr_addr_reg)) // [RULE_11]
          4'h3:    inten_reg  <= hwdata[1:0];
          4'h4:    refctl_reg <= hwdata & `ACC_REF_MASK;
          4'h6:    ctl_reg[0] <= hwdata & `ACC_CTL_MASK;
          4'h8:    ctl_reg[1] <= hwdata & `ACC_CTL_MASK;
          default: inten_reg  <= inten_reg;
        endcase
      end
    end
  end

  // Read data registered for the data phase
  always @(posedge clk)
  begin
    if (!rst_n)
      hrdata <= `ACC_RST_ZERO;
    else if (rd_now)
    begin
      case (reg_sel(off))
        4'h1:    hrdata <= {30'h00000000, mis};
        4'h2:    hrdata <= {30'h00000000, ris_reg};
        4'h3:    hrdata <= {30'h00000000, inten_reg};
        4'h4:    hrdata <= refctl_reg;
        4'h5:    hrdata <= {30'h00000000, result[0], 1'b0}; // [RULE_14]
        4'h6:    hrdata <= ctl_reg[0];
        4'h7:    hrdata <= {30'h00000000, result[1], 1'b0}; // [RULE_14]
        4'h8:    hrdata <= ctl_reg[1];
        default: hrdata <= `ACC_RST_ZERO;
      endcase
    end
  end

  // Shared pin carries cmp0 output only; cmp1 never drives it
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      shared_pin_out <= 1'b0;
      shared_pin_oe  <= 1'b0;
      irq            <= 1'b0;
    end
    else
    begin
      shared_pin_out <= result[0]; // [RULE_05] [RULE_09]
      shared_pin_oe  <= ctl_reg[0][`ACC_CTL_TOEN_BIT]; // [RULE_13]
      irq            <= |(ris_next & inten_reg); // [RULE_06] [RULE_10]
    end
  end
endmodule // acc_top

// [src/acc_consts.vh]
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH
// Register byte offsets
`define ACC_OFF_MIS      8'h00
`define ACC_OFF_RIS      8'h04
`define ACC_OFF_INTEN    8'h08
`define ACC_OFF_REFCTL   8'h10
`define ACC_OFF_STAT0    8'h20
`define ACC_OFF_CTL0     8'h24
`define ACC_OFF_STAT1    8'h40
`define ACC_OFF_CTL1     8'h44
// Control register fields
`define ACC_CTL_INV_BIT  1
`define ACC_CTL_ISEN_LO  2
`define ACC_CTL_ISEN_HI  3
`define ACC_CTL_SRC_LO   9
`define ACC_CTL_SRC_HI   10
`define ACC_CTL_TOEN_BIT 11
`define ACC_CTL_MASK     32'h00000E0E
// Status register field
`define ACC_STAT_VAL_BIT 1
// Reference control fields
`define ACC_REF_MASK     32'h0000030F
`define ACC_REF_EN_BIT   9
`define ACC_REF_RNG_BIT  8
`define ACC_REF_TAP_HI   3
`define ACC_REF_TAP_LO   0
// Positive source select codes
`define ACC_SRC_OWN0     2'h0
`define ACC_SRC_OWN1     2'h1
`define ACC_SRC_VREF     2'h2
`define ACC_SRC_RSVD     2'h3
// Interrupt sense codes
`define ACC_SENSE_LEVEL  2'h0
`define ACC_SENSE_FALL   2'h1
`define ACC_SENSE_RISE   2'h2
`define ACC_SENSE_BOTH   2'h3
// Reset values
`define ACC_RST_ZERO     32'h00000000
`endif

// [src/acc_sync.v]
// Two-flop synchroniser for an asynchronous comparator level
module acc_sync (
  clk,      // System clock
  rst_n,    // Synchronous reset, active low
  async_in, // Raw comparator level
  sync_out  // Level in the clock domain
);
  input  wire clk;      // System clock
  input  wire rst_n;    // Reset, active low
  input  wire async_in; // Raw level
  output reg  sync_out; // Synchronised level

  reg meta_reg; // First stage, read only by second stage

  // Two stages to settle metastability
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_reg <= async_in; // [RULE_15]
      sync_out <= meta_reg;
    end
  end
endmodule // acc_sync

// [src/acc_unit.v]
`include "acc_consts.vh"
// One comparator unit: result sync, inversion and event detection
module acc_unit (
  clk,       // System clock
  rst_n,     // Synchronous reset, active low
  raw_cmp,   // Analog result, 1 when negative input below positive
  invert,    // Invert the result
  sense,     // Interrupt sense selection
  result,    // Synchronised, inverted result
  event_hit  // Event: result level in level mode, one-cycle pulse in edge modes
);
  input  wire       clk;       // System clock
  input  wire       rst_n;     // Reset, active low
  input  wire       raw_cmp;   // Analog result
  input  wire       invert;    // Inversion control
  input  wire [1:0] sense;     // Sense mode
  output reg        result;    // Registered result
  output wire       event_hit; // Event pulse

  wire sync_val; // Synchronised result
  reg  prev_reg; // Previous result for edge detect

  acc_sync u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (raw_cmp),
    .sync_out (sync_val)
  );

  // Register result after inversion
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      result   <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      result   <= sync_val ^ invert; // [RULE_03] [RULE_15]
      prev_reg <= result;
    end
  end

  // Event per sense mode
  assign event_hit = (sense == `ACC_SENSE_LEVEL) ? result :
                     (sense == `ACC_SENSE_FALL)  ? (prev_reg & ~result) :
                     (sense == `ACC_SENSE_RISE)  ? (~prev_reg & result) :
                     (prev_reg ^ result);
endmodule // acc_unit

// [dv/acc_top_monitor.sv]
`include "acc_consts.vh"
module acc_top_monitor (
  input wire logic        clk,             // Clock
  input wire logic        rst_n,           // Reset, low
  input wire logic [31:0] haddr,           // Address
  input wire logic [1:0]  htrans,          // Transfer
  input wire logic        hwrite,          // Write
  input wire logic [31:0] hwdata,          // Write data
  input wire logic        hsel,            // Select
  input wire logic        hready,          // Bus ready
  input wire logic        hreadyout,       // Slave ready
  input wire logic        hresp,           // Response
  input wire logic        cmp0_result_raw, // Raw result 0
  input wire logic [1:0]  cmp0_pos_sel,    // Mux 0
  input wire logic [1:0]  cmp1_pos_sel,    // Mux 1
  input wire logic        ref_enable,      // Ladder on
  input wire logic        ref_range,       // Range
  input wire logic [3:0]  ref_tap,         // Tap
  input wire logic        shared_pin_out,  // Pin value
  input wire logic        shared_pin_oe,   // Pin enable
  input wire logic        irq              // Interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] wd_q; // Write word of the last data phase
  // Holds the committed word for comparison after the commit edge
  always_ff @(posedge clk)
  begin
    wd_q <= hwdata;
  end
  // Address phase of a write followed by its data phase
  sequence s_wr(logic [7:0] off);
    hsel && hready && htrans[1] && hwrite && haddr[7:0] == off ##1 1'b1;
  endsequence
  a_resp_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not OKAY");
  a_src0_map: assert property (s_wr(`ACC_OFF_CTL0) |=> cmp0_pos_sel == wd_q[10:9])
    else $error("cmp0 source select differs from control write");
  a_src1_map: assert property (s_wr(`ACC_OFF_CTL1) |=> cmp1_pos_sel == wd_q[10:9])
    else $error("cmp1 source select differs from control write");
  a_ladder_map: assert property (s_wr(`ACC_OFF_REFCTL) |=>
    {ref_enable, ref_range, ref_tap} == {wd_q[9:8], wd_q[3:0]})
    else $error("ladder outputs differ from reference write");
  a_pin_drive_on: assert property (s_wr(`ACC_OFF_CTL0) ##0 hwdata[11] |-> ##[1:2] shared_pin_oe)
    else $error("shared pin not driven after enable");
  a_pin_drive_off: assert property (s_wr(`ACC_OFF_CTL0) ##0 !hwdata[11] |-> ##[1:2] !shared_pin_oe)
    else $error("shared pin still driven after disable");
  // Masked events that arrive soon after the write must stay off the line
  a_irq_masked: assert property (s_wr(`ACC_OFF_INTEN) ##0 hwdata[1:0] == 2'h0 |-> ##2 !irq [*8])
    else $error("interrupt high with all sources masked");
  // Two sync stages plus result and pin flops: no reaction for three edges
  a_sync_delay: assert property ($rose(cmp0_result_raw) |=> $stable(shared_pin_out) [*3])
    else $error("pin followed raw result without synchronising");
endmodule // acc_top_monitor

bind acc_top acc_top_monitor u_mon (.clk(clk), .rst_n(rst_n), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hsel(hsel), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .cmp0_result_raw(cmp0_result_raw), .cmp0_pos_sel(cmp0_pos_sel),
  .cmp1_pos_sel(cmp1_pos_sel), .ref_enable(ref_enable), .ref_range(ref_range),
  .ref_tap(ref_tap), .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe), .irq(irq));

// [dv/acc_analog_model.sv]
// Pad digital input buffers are taken as disabled on all analog pins
module acc_analog_model (
  input wire logic [1:0]  cmp0_pos_sel,    // Cmp0 positive source
  input wire logic [1:0]  cmp1_pos_sel,    // Cmp1 positive source
  input wire logic        ref_enable,      // Ladder on
  input wire logic        ref_range,       // Ladder range
  input wire logic [3:0]  ref_tap,         // Ladder tap
  input wire logic        shared_pin_out,  // Cmp0 pin level
  input wire logic        shared_pin_oe,   // Cmp0 drives pin
  input wire logic [11:0] v0_neg,          // Cmp0 negative pin, mV
  input wire logic [11:0] v0_pos,          // Cmp0 positive pin, mV
  input wire logic [11:0] v1_neg_ext,      // Outside level on shared pin, mV
  output logic            cmp0_result_raw, // Cmp0 analog result
  output logic            cmp1_result_raw  // Cmp1 analog result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] vref; // Ladder voltage
  logic [11:0] p0;   // Cmp0 positive input
  logic [11:0] p1;   // Cmp1 positive input
  logic [11:0] n1;   // Cmp1 negative input
  // Ladder, mux and comparison on a 3.3 V supply
  always_comb
  begin
    vref = !ref_enable ? 12'h000 : ref_range ? 12'(3300 * ref_tap / 24)
                                             : 12'(3300 * (ref_tap + 8) / 32);
    p0 = cmp0_pos_sel[1] ? (cmp0_pos_sel[0] ? 12'h000 : vref) : v0_pos;
    p1 = cmp1_pos_sel == 2'h1 ? v0_pos : cmp1_pos_sel == 2'h2 ? vref : 12'h000;
    n1 = shared_pin_oe ? (shared_pin_out ? 12'hCE4 : 12'h000) : v1_neg_ext;
    cmp0_result_raw = v0_neg < p0;
    cmp1_result_raw = n1 < p1;
  end
endmodule // acc_analog_model

// [dv/tb_top.sv]
`include "acc_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed { logic [31:0] rc, c0, c1; logic [11:0] vn0, vp0, vn1; logic e0, e1; } acc_row_t;
  logic clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, hsel = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, d;
  logic [1:0] htrans = 2'h0;
  logic [11:0] vn0 = 12'h7D0, vp0 = 12'h3E8, vn1 = 12'h000;
  wire [31:0] hrdata;
  wire hreadyout, hresp, raw0, raw1, ren, rrng, pout, poe, irq;
  wire [1:0] sel0, sel1;
  wire [3:0] rtap;
  int fail_count = 0, compares = 0, cycles = 0;
  acc_row_t rows [5] = '{
    '{32'h30C, 32'h000, 32'h200, 12'h3E8, 12'h7D0, 12'h9C4, 1'b1, 1'b0},
    '{32'h30C, 32'h202, 32'h400, 12'h3E8, 12'h7D0, 12'h3E8, 1'b0, 1'b1},
    '{32'h30C, 32'hC00, 32'h402, 12'h3E8, 12'h7D0, 12'h3E8, 1'b1, 1'b1},
    '{32'h200, 32'h400, 32'h400, 12'h384, 12'h7D0, 12'h2BC, 1'b0, 1'b1},
    '{32'h000, 32'h400, 32'h202, 12'h064, 12'hBB8, 12'hC1C, 1'b0, 1'b1}};
  logic [7:0] offs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h24, 8'h40, 8'h44};
  acc_top dut (.clk(clk), .rst_n(rst_n), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cmp0_result_raw(raw0), .cmp1_result_raw(raw1),
    .cmp0_pos_sel(sel0), .cmp1_pos_sel(sel1), .ref_enable(ren), .ref_range(rrng),
    .ref_tap(rtap), .shared_pin_out(pout), .shared_pin_oe(poe), .irq(irq));
  acc_analog_model u_analog (.cmp0_pos_sel(sel0), .cmp1_pos_sel(sel1), .ref_enable(ren),
    .ref_range(rrng), .ref_tap(rtap), .shared_pin_out(pout), .shared_pin_oe(poe),
    .v0_neg(vn0), .v0_pos(vp0), .v1_neg_ext(vn1), .cmp0_result_raw(raw0),
    .cmp1_result_raw(raw1));
  // 40 MHz clock
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // Compares one value and counts the outcome
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One single AHB-Lite transfer; waits for ready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Prints the counts and the verdict, then ends the run
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end
  initial
  begin
    wt(5);
    rst_n <= 1'b1;
    // Source selection, reference, inversion and pin per row
    foreach (rows[i])
    begin
      bus(1'b1, `ACC_OFF_REFCTL, rows[i].rc, d);
      bus(1'b1, `ACC_OFF_CTL0, rows[i].c0, d);
      bus(1'b1, `ACC_OFF_CTL1, rows[i].c1, d);
      vn0 <= rows[i].vn0;
      vp0 <= rows[i].vp0;
      vn1 <= rows[i].vn1;
      wt(4);
      bus(1'b0, `ACC_OFF_STAT0, 32'h0, d);
      chk("status0", d, {30'h0, rows[i].e0, 1'b0});
      bus(1'b0, `ACC_OFF_STAT1, 32'h0, d);
      chk("status1", d, {30'h0, rows[i].e1, 1'b0});
      chk("pin", {poe, poe & pout}, {rows[i].c0[11], rows[i].c0[11] & rows[i].e0});
    end
    $display("Test rows done");
    // Second reset with both results low, then every register and a hole
    vn0 <= 12'h7D0;
    vp0 <= 12'h3E8;
    rst_n <= 1'b0;
    wt(5);
    rst_n <= 1'b1;
    wt(4);
    foreach (offs[i])
    begin
      bus(1'b0, offs[i], 32'h0, d);
      chk("reset value", d, `ACC_RST_ZERO);
    end
    chk("pin after reset", {irq, poe}, 32'h0);
    $display("Test reset done");
    // Reserved bits, reserved source code and an unmapped write
    bus(1'b1, `ACC_OFF_CTL0, 32'hFFFFFFFF, d);
    bus(1'b0, `ACC_OFF_CTL0, 32'h0, d);
    chk("ctl0 mask", d, `ACC_CTL_MASK);
    chk("src reserved", sel0, `ACC_SRC_RSVD);
    bus(1'b1, `ACC_OFF_REFCTL, 32'hFFFFFFFF, d);
    bus(1'b0, `ACC_OFF_REFCTL, 32'h0, d);
    chk("ref mask", d, `ACC_REF_MASK);
    bus(1'b1, 8'h0C, 32'hFFFFFFFF, d);
    bus(1'b0, 8'h0C, 32'h0, d);
    chk("unmapped", d, 32'h0);
    $display("Test reserved done");
    // Rising-edge interrupt on cmp0, then a falling edge that must not fire
    bus(1'b1, `ACC_OFF_CTL0, 32'h00000008, d);
    wt(5);
    bus(1'b0, `ACC_OFF_RIS, 32'h0, d);
    bus(1'b1, `ACC_OFF_INTEN, 32'h1, d);
    vn0 <= 12'h1F4;
    wt(6);
    chk("irq rise", irq, 32'h1);
    bus(1'b0, `ACC_OFF_MIS, 32'h0, d);
    chk("masked status", d, 32'h1);
    vn0 <= 12'h7D0;
    wt(6);
    chk("irq fall ignored", irq, 32'h0);
    // Masked event stays pending, shows when unmasked, write-one clears
    bus(1'b1, `ACC_OFF_INTEN, 32'h0, d);
    vn0 <= 12'h1F4;
    wt(6);
    chk("irq masked", irq, 32'h0);
    bus(1'b1, `ACC_OFF_INTEN, 32'h1, d);
    wt(3);
    chk("irq unmasked", irq, 32'h1);
    bus(1'b1, `ACC_OFF_MIS, 32'h1, d);
    wt(3);
    chk("irq cleared", irq, 32'h0);
    // Falling-edge event on cmp1 against the cmp0 positive pin
    bus(1'b1, `ACC_OFF_CTL1, 32'h00000204, d);
    vn1 <= 12'h1F4;
    wt(5);
    bus(1'b0, `ACC_OFF_RIS, 32'h0, d);
    bus(1'b1, `ACC_OFF_INTEN, 32'h2, d);
    vn1 <= 12'h5DC;
    wt(6);
    chk("irq cmp1", irq, 32'h1);
    bus(1'b0, `ACC_OFF_RIS, 32'h0, d);
    chk("raw status", d, 32'h2);
    $display("Test interrupts done");
    stop_test();
  end
endmodule // tb_top
